// ===== rtl/rsq_pkg.sv
// Purpose: Shared constants and types of the reset sequencer and arbiter
// Assumes: Counts are in reference clock falling edges
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus
package rsq_pkg;
	// ------------------------------------------------------------------
	// Counter geometry and sequence lengths
	// ------------------------------------------------------------------
	localparam int CNT_W = 12;
	localparam logic [11:0] STAB_LAST = 12'hFFF;
	localparam logic [11:0] SHORT_WAKE_LAST = 12'h01F;
	localparam int PHASE_W = 6;
	localparam logic [5:0] PIN_DRIVE_LAST = 6'h1F;
	localparam logic [5:0] INT_HOLD_LAST = 6'h1F;
	localparam logic [5:0] EXT_HOLD_LAST = 6'h3F;
	// ------------------------------------------------------------------
	// Opcodes watched on the fetch path
	// ------------------------------------------------------------------
	localparam logic [7:0] OP_SP_PREFIX = 8'h9E;
	localparam logic [7:0] OP_STOP = 8'h8E;
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_CAUSE = 8'h00;
	localparam logic [7:0] ADR_CONFIG = 8'h04;
	localparam logic [7:0] ADR_IRQ_EN = 8'h08;
	localparam logic [7:0] ADR_WDOG = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	// Reset cause bit positions
	localparam int CB_POWER_ON = 7;
	localparam int CB_PIN = 6;
	localparam int CB_WATCHDOG = 5;
	localparam int CB_BAD_OPCODE = 4;
	localparam int CB_BAD_ADDRESS = 3;
	localparam int CB_LOW_VOLTAGE = 1;
	localparam logic [7:0] CAUSE_POR_VALUE = 8'h80;
	// Option bit positions and reset value
	localparam int OB_WD_DISABLE = 0;
	localparam int OB_STOP_ENABLE = 1;
	localparam int OB_SHORT_WAKE = 2;
	localparam int OB_LV_RESET_OFF = 3;
	localparam int OB_LV_MONITOR_OFF = 4;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	// Registers pushed on interrupt entry: pc, x, a, ccr; never index high
	localparam logic [4:0] STACK_SET = 5'h0F;
	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STAB, ST_LV_HOLD, ST_PIN_DRIVE, ST_INT_HOLD,
		ST_EXT_HOLD, ST_RUN, ST_STOP, ST_WAKE
	} rsq_state_type;
	typedef struct packed {
		logic opcode_fetch;
		logic fetch_unmapped;
		logic illegal_opcode;
		logic instr_done;
		logic i_mask;
		logic irq_serviced;
		logic [7:0] fetch_data;
	} rsq_cpu_type;
endpackage : rsq_pkg

// ===== rtl/rsq_reset_seq.sv
// Purpose: Reset sequencing, cause flags, stabilization counter, watchdog
//          and interrupt latch and arbitration
// Assumes: clk_i at 25 MHz; reference clock and pin inputs are asynchronous
// Notes: Behaviour
`timescale 1ns/1ns
module rsq_reset_seq #(
	parameter int N_IRQ = 24,
	parameter int CODE_W = 5,
	parameter int WD_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Asynchronous sources
	input wire logic osc_ref_clock_i,
	input wire logic power_on_pulse_i,
	input wire logic low_voltage_i,
	input wire logic break_i,
	// Reset pin, open drain
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	// CPU side
	input rsq_pkg::rsq_cpu_type cpu_i,
	input wire logic [N_IRQ-1:0] irq_req_i,
	output logic internal_reset_o,
	output logic clocks_enable_o,
	output logic generator_clock_out_o,
	output logic watchdog_tick_o,
	output logic irq_pending_o,
	output logic [CODE_W-1:0] irq_code_o,
	output logic [4:0] stack_sel_o,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [rsq_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
	logic por_s1_reg, por_s2_reg;
	logic lv_s1_reg, lv_s2_reg;
	logic brk_s1_reg, brk_s2_reg;
	logic pin_s1_reg, pin_s2_reg, oe_d1_reg, oe_d2_reg;
	logic tick;

	always_ff @(posedge clk_i) begin
		ref_s1_reg <= osc_ref_clock_i;
		ref_s2_reg <= ref_s1_reg;
		ref_s3_reg <= ref_s2_reg;
		por_s1_reg <= power_on_pulse_i;
		por_s2_reg <= por_s1_reg;
		lv_s1_reg <= low_voltage_i;
		lv_s2_reg <= lv_s1_reg;
		brk_s1_reg <= break_i;
		brk_s2_reg <= brk_s1_reg;
		pin_s1_reg <= rst_pin_i;
		pin_s2_reg <= pin_s1_reg;
		oe_d1_reg <= rst_pin_oe_o;
		oe_d2_reg <= oe_d1_reg;
	end

	assign tick = ref_s3_reg && !ref_s2_reg;

	// ------------------------------------------------------------------
	// Registers and shared state
	// ------------------------------------------------------------------
	rsq_pkg::rsq_state_type state_reg, state_next;
	logic [rsq_pkg::CNT_W-1:0] cnt_reg;
	logic [rsq_pkg::PHASE_W-1:0] phase_reg;
	logic [WD_W-1:0] wd_reg;
	logic [7:0] cause_reg, cause_next, config_reg;
	logic [N_IRQ-1:0] irq_en_reg;
	logic prefix_reg, wake_short_reg, mask_prev_reg;
	logic cnt_ovf, cnt_clear, wd_ovf, wd_kick, pin_low;
	logic por_ev, lv_ev, wd_ev, bad_opcode_flag_ev, bad_address_flag_ev, stoprec_ev, stop_enter;
	logic int_ev, wake_ev, run, wb_req, cause_rd;
	logic [N_IRQ-1:0] req_en;

	assign run = state_reg == rsq_pkg::ST_RUN;
	assign pin_low = !pin_s2_reg && !rst_pin_oe_o && !oe_d1_reg &&
		!oe_d2_reg;
	assign cnt_ovf = tick && cnt_reg == rsq_pkg::STAB_LAST;
	assign wd_ovf = cnt_ovf && (&wd_reg) && run;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cause_rd = wb_req && !wb_we_i && wb_adr_i == rsq_pkg::ADR_CAUSE;
	assign wd_kick = wb_req && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == rsq_pkg::ADR_WDOG;
	assign req_en = irq_req_i & irq_en_reg;

	// ------------------------------------------------------------------
	// Reset source decode
	// ------------------------------------------------------------------
	logic stop_fetch;
	assign stop_fetch = cpu_i.opcode_fetch &&
		cpu_i.fetch_data == rsq_pkg::OP_STOP;
	assign por_ev = por_s2_reg;
	assign lv_ev = lv_s2_reg && !config_reg[rsq_pkg::OB_LV_MONITOR_OFF] &&
		!config_reg[rsq_pkg::OB_LV_RESET_OFF];
	assign wd_ev = wd_ovf && !config_reg[rsq_pkg::OB_WD_DISABLE];
	assign stoprec_ev = run && stop_fetch && prefix_reg;
	assign bad_opcode_flag_ev = run && (cpu_i.illegal_opcode || (stop_fetch &&
		!prefix_reg && !config_reg[rsq_pkg::OB_STOP_ENABLE]));
	assign bad_address_flag_ev = run && cpu_i.opcode_fetch &&
		cpu_i.fetch_unmapped;
	assign stop_enter = run && stop_fetch && !prefix_reg &&
		config_reg[rsq_pkg::OB_STOP_ENABLE];
	assign int_ev = wd_ev || bad_opcode_flag_ev || bad_address_flag_ev || stoprec_ev;
	assign wake_ev = (|req_en) || brk_s2_reg || pin_low;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prefix_reg <= 1'b0;
		end else if (cpu_i.opcode_fetch) begin
			prefix_reg <= cpu_i.fetch_data == rsq_pkg::OP_SP_PREFIX;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		if (por_ev) begin
			state_next = rsq_pkg::ST_STAB;
		end else if (lv_ev) begin
			state_next = rsq_pkg::ST_LV_HOLD;
		end else if (int_ev) begin
			state_next = rsq_pkg::ST_PIN_DRIVE;
		end else begin
			case (state_reg)
			rsq_pkg::ST_STAB: begin
				if (cnt_ovf) begin
					state_next = rsq_pkg::ST_PIN_DRIVE;
				end
			end
			rsq_pkg::ST_LV_HOLD: begin
				state_next = rsq_pkg::ST_STAB;
			end
			rsq_pkg::ST_PIN_DRIVE: begin
				if (tick && phase_reg == rsq_pkg::PIN_DRIVE_LAST) begin
					state_next = rsq_pkg::ST_INT_HOLD;
				end
			end
			rsq_pkg::ST_INT_HOLD: begin
				if (tick && phase_reg == rsq_pkg::INT_HOLD_LAST) begin
					state_next = rsq_pkg::ST_RUN;
				end
			end
			rsq_pkg::ST_EXT_HOLD: begin
				if (!pin_low && tick && phase_reg == rsq_pkg::EXT_HOLD_LAST) begin
					state_next = rsq_pkg::ST_RUN;
				end
			end
			rsq_pkg::ST_RUN: begin
				if (pin_low) begin
					state_next = rsq_pkg::ST_EXT_HOLD;
				end else if (stop_enter) begin
					state_next = rsq_pkg::ST_STOP;
				end
			end
			rsq_pkg::ST_STOP: begin
				if (wake_ev) begin
					state_next = rsq_pkg::ST_WAKE;
				end
			end
			rsq_pkg::ST_WAKE: begin
				if (wake_short_reg ? (tick && cnt_reg == rsq_pkg::SHORT_WAKE_LAST)
					: cnt_ovf) begin
					state_next = rsq_pkg::ST_RUN;
				end
			end
			default: begin
				state_next = rsq_pkg::ST_STAB;
			end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= rsq_pkg::ST_STAB;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_short_reg <= 1'b0;
		end else if (state_reg == rsq_pkg::ST_STOP && wake_ev) begin
			wake_short_reg <= config_reg[rsq_pkg::OB_SHORT_WAKE];
		end
	end

	// ------------------------------------------------------------------
	// Stabilization counter, phase counter and watchdog
	// ------------------------------------------------------------------
	assign cnt_clear = por_ev || lv_ev || int_ev || stop_enter ||
		state_reg == rsq_pkg::ST_STOP;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
		end else if (cnt_clear) begin
			cnt_reg <= '0;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_next != state_reg || pin_low) begin
			phase_reg <= '0;
		end else if (tick) begin
			phase_reg <= phase_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !run || wd_kick) begin
			wd_reg <= '0;
		end else if (cnt_ovf) begin
			wd_reg <= wd_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Outputs toward pin and CPU
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_pin_o <= 1'b0;
			rst_pin_oe_o <= 1'b1;
			internal_reset_o <= 1'b1;
			clocks_enable_o <= 1'b0;
			generator_clock_out_o <= 1'b1;
			watchdog_tick_o <= 1'b0;
			stack_sel_o <= rsq_pkg::STACK_SET;
		end else begin
			rst_pin_o <= 1'b0;
			rst_pin_oe_o <= state_next == rsq_pkg::ST_STAB ||
				state_next == rsq_pkg::ST_LV_HOLD ||
				state_next == rsq_pkg::ST_PIN_DRIVE;
			internal_reset_o <= state_next != rsq_pkg::ST_RUN &&
				state_next != rsq_pkg::ST_STOP &&
				state_next != rsq_pkg::ST_WAKE;
			clocks_enable_o <= state_next != rsq_pkg::ST_STAB &&
				state_next != rsq_pkg::ST_LV_HOLD &&
				state_next != rsq_pkg::ST_STOP &&
				state_next != rsq_pkg::ST_WAKE;
			generator_clock_out_o <= state_next != rsq_pkg::ST_STOP;
			watchdog_tick_o <= cnt_ovf;
			stack_sel_o <= rsq_pkg::STACK_SET;
		end
	end

	// ------------------------------------------------------------------
	// Reset cause flags
	// ------------------------------------------------------------------
	always_comb begin
		cause_next = cause_reg;
		if (cause_rd) begin
			cause_next = '0;
		end
		if (pin_low && run) begin
			cause_next[rsq_pkg::CB_PIN] = 1'b1;
		end
		if (wd_ev) begin
			cause_next[rsq_pkg::CB_WATCHDOG] = 1'b1;
		end
		if (bad_opcode_flag_ev || stoprec_ev) begin
			cause_next[rsq_pkg::CB_BAD_OPCODE] = 1'b1;
		end
		if (bad_address_flag_ev) begin
			cause_next[rsq_pkg::CB_BAD_ADDRESS] = 1'b1;
		end
		if (lv_ev) begin
			cause_next[rsq_pkg::CB_LOW_VOLTAGE] = 1'b1;
		end
		if (por_ev) begin
			cause_next = rsq_pkg::CAUSE_POR_VALUE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_reg <= rsq_pkg::CAUSE_POR_VALUE;
		end else begin
			cause_reg <= cause_next;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt latch and arbitration
	// ------------------------------------------------------------------
	function automatic logic [CODE_W-1:0] pick(input logic [N_IRQ-1:0] r);
		logic [CODE_W-1:0] c;
		c = '0;
		for (int i = N_IRQ - 1; i >= 0; i--) begin
			if (r[i]) begin
				c = CODE_W'(i);
			end
		end
		return c;
	endfunction : pick

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_prev_reg <= 1'b1;
		end else begin
			mask_prev_reg <= cpu_i.i_mask;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_next != rsq_pkg::ST_RUN) begin
			irq_pending_o <= 1'b0;
			irq_code_o <= '0;
		end else if (irq_pending_o) begin
			if (cpu_i.irq_serviced || (mask_prev_reg && !cpu_i.i_mask)) begin
				irq_pending_o <= 1'b0;
			end
		end else if (cpu_i.instr_done && !cpu_i.i_mask && (|req_en)) begin
			irq_pending_o <= 1'b1;
			irq_code_o <= pick(req_en);
		end
	end

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_reg <= rsq_pkg::CONFIG_RESET;
			irq_en_reg <= '0;
		end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == rsq_pkg::ADR_CONFIG) begin
				config_reg <= wb_dat_i[7:0];
			end
			if (wb_adr_i == rsq_pkg::ADR_IRQ_EN) begin
				irq_en_reg <= wb_dat_i[N_IRQ-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= '0;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
				rsq_pkg::ADR_CAUSE: begin
					wb_dat_o <= {24'h000000, cause_reg};
				end
				rsq_pkg::ADR_CONFIG: begin
					wb_dat_o <= {24'h000000, config_reg};
				end
				rsq_pkg::ADR_IRQ_EN: begin
					wb_dat_o <= 32'(irq_en_reg);
				end
				rsq_pkg::ADR_STATUS: begin
					wb_dat_o <= 32'({clocks_enable_o, internal_reset_o,
						irq_pending_o, irq_code_o});
				end
				default: begin
					wb_dat_o <= '0;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	stab_pin_low_a: assert property (
		state_reg == rsq_pkg::ST_STAB && !por_ev && !lv_ev && !cnt_ovf |=>
		rst_pin_oe_o && internal_reset_o && !clocks_enable_o)
		else $error("stabilization without pin low or clocks gated");
	por_cause_a: assert property (
		por_ev |=> cause_reg == rsq_pkg::CAUSE_POR_VALUE)
		else $error("power-on cause not exclusive");
	wd_reset_a: assert property (
		wd_ev && !por_ev && !lv_ev |=> state_reg == rsq_pkg::ST_PIN_DRIVE
		&& cause_reg[rsq_pkg::CB_WATCHDOG] && rst_pin_oe_o)
		else $error("watchdog overflow did not reset");
	bad_addr_a: assert property (
		bad_address_flag_ev && !por_ev && !lv_ev |=> cause_reg[rsq_pkg::CB_BAD_ADDRESS]
		&& state_reg == rsq_pkg::ST_PIN_DRIVE)
		else $error("unmapped opcode fetch did not reset");
	stop_clear_a: assert property (
		stop_enter && !por_ev && !lv_ev && !int_ev && !pin_low |=>
		state_reg == rsq_pkg::ST_STOP && cnt_reg == '0 &&
		!generator_clock_out_o)
		else $error("stop did not clear counter");
	ext_count_a: assert property (
		state_reg == rsq_pkg::ST_EXT_HOLD && tick && !cnt_clear |=>
		cnt_reg == $past(cnt_reg) + 1'b1)
		else $error("pin reset disturbed counter");
	hold_tail_a: assert property (
		state_reg == rsq_pkg::ST_INT_HOLD && $past(state_reg) ==
		rsq_pkg::ST_PIN_DRIVE |-> phase_reg == '0 && !rst_pin_oe_o)
		else $error("internal hold did not restart phase");
	irq_hold_a: assert property (
		irq_pending_o && !cpu_i.irq_serviced && cpu_i.i_mask && run &&
		state_next == rsq_pkg::ST_RUN |=> irq_pending_o &&
		$stable(irq_code_o))
		else $error("latched interrupt preempted");
	irq_take_a: assert property (
		$rose(irq_pending_o) |-> $past(cpu_i.instr_done) &&
		!$past(cpu_i.i_mask))
		else $error("interrupt taken mid instruction or masked");
	reset_prio_a: assert property (
		internal_reset_o |-> !irq_pending_o)
		else $error("interrupt pending during reset");
	read_clear_a: assert property (
		cause_rd && !por_ev && !lv_ev && !int_ev && !(pin_low && run) |=>
		cause_reg == '0)
		else $error("cause read did not clear flags");

	por_run_c: cover property (state_reg == rsq_pkg::ST_INT_HOLD ##1
		state_reg == rsq_pkg::ST_RUN);
	wd_reset_c: cover property (wd_ev);
	irq_latch_c: cover property ($rose(irq_pending_o));
	stop_wake_c: cover property (state_reg == rsq_pkg::ST_WAKE ##1
		state_reg == rsq_pkg::ST_RUN);
endmodule : rsq_reset_seq

// ===== tb/rsq_far_model.sv
// Purpose: Far side of the sequencer: reference oscillator and reset pin
// Assumes: Pin has a pull-up; oscillator runs free at a quarter of clk_i
// Notes: An external party may pull the pin low through ext_low_i
`timescale 1ns/1ns
module rsq_far_model (
	// Clock
	input wire logic clk_i,
	// Pin side
	input wire logic pin_drv_i,
	input wire logic pin_oe_i,
	input wire logic ext_low_i,
	// Outputs
	output logic osc_ref_clock_o,
	output logic pin_level_o
);
	logic div_reg = 1'b0;
	logic osc_reg = 1'b0;
	always_ff @(posedge clk_i) begin
		div_reg <= ~div_reg;
		if (div_reg) osc_reg <= ~osc_reg;
	end
	assign osc_ref_clock_o = osc_reg;
	// Open drain with pull-up: low when anyone pulls
	assign pin_level_o = (pin_oe_i ? pin_drv_i : 1'b1) & ~ext_low_i;
endmodule : rsq_far_model

// ===== tb/rsq_reset_seq_tb.sv
// Purpose: Self-checking bench of the reset sequencer and arbiter
// Assumes: One reference tick every four clk_i cycles
// Notes: Tick counts except the watchdog interval are checked with a small margin for synchronizers
`timescale 1ns/1ns
module rsq_reset_seq_tb;
	localparam logic [5:0] F_OP = 6'h20, F_UNM = 6'h10, F_ILL = 6'h08;
	localparam logic [5:0] F_DONE = 6'h04, F_MASK = 6'h02, F_SERV = 6'h01;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por = 1'b0, lv = 1'b0, brk = 1'b0, ext_low = 1'b0, osc, pin_lvl;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0, wb_rd, seed = 32'h0db2;
	logic [23:0] irq = 24'h0;
	rsq_pkg::rsq_cpu_type cpu = '0;
	logic pin_o, pin_oe, internal_reset, clk_en, gen_clk, wd_tick, pend, wb_ack;
	logic [4:0] code, stk;
	logic [31:0] exp_q[$];
	logic [5:0] fl[4] = '{F_OP | F_UNM, F_ILL, F_OP, F_OP};
	logic [7:0] cs[4] = '{8'h08, 8'h10, 8'h10, 8'h10};
	int n_fail = 0, cmp_count = 0, ticks = 0, t0, n_wd = 0;
	always #20 clk_i = ~clk_i;
	always @(negedge osc) ticks++;
	always @(posedge clk_i)
		if (wd_tick === 1'b1 && pin_oe === 1'b1) n_wd++;
	rsq_far_model i_rsq_far_model (.clk_i(clk_i), .pin_drv_i(pin_o),
		.pin_oe_i(pin_oe), .ext_low_i(ext_low), .osc_ref_clock_o(osc),
		.pin_level_o(pin_lvl));
	rsq_reset_seq #(.WD_W(1)) i_rsq_reset_seq (.clk_i(clk_i),
		.rst_i(rst_i),
		.osc_ref_clock_i(osc), .power_on_pulse_i(por), .low_voltage_i(lv),
		.break_i(brk), .rst_pin_i(pin_lvl), .rst_pin_o(pin_o),
		.rst_pin_oe_o(pin_oe), .cpu_i(cpu), .irq_req_i(irq),
		.internal_reset_o(internal_reset), .clocks_enable_o(clk_en),
		.generator_clock_out_o(gen_clk), .watchdog_tick_o(wd_tick),
		.irq_pending_o(pend), .irq_code_o(code), .stack_sel_o(stk),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_rd), .wb_ack_o(wb_ack));
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] in_rng(input int v, lo, hi);
		return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
	endfunction : in_rng
	task automatic report_and_stop;
		if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wait_lvl(input int sel, input logic lvl);
		int k;
		logic s;
		k = 0;
		do begin
			@(negedge clk_i);
			s = (sel == 0) ? internal_reset : (sel == 1) ? pin_oe : clk_en;
			k++;
		end while (s !== lvl && k < 40000);
		if (k >= 40000) begin
			n_fail++;
			report_and_stop();
		end
	endtask : wait_lvl
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hF;
		do begin
			@(negedge clk_i);
			k++;
		end while (wb_ack !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_fail++;
			report_and_stop();
		end
		@(posedge clk_i);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask : rd
	task automatic cpu_op(input logic [5:0] f, input logic [7:0] d);
		@(posedge clk_i);
		cpu <= {f, d};
		@(posedge clk_i);
		cpu <= {4'h0, f[1], 9'h000};
	endtask : cpu_op
	task automatic seq(input int lo, hi);
		int w0;
		w0 = n_wd;
		wait_lvl(1, 1'b0);
		chk("pin ticks", in_rng(ticks - t0, lo, hi), 32'h1);
		chk("wd tick", n_wd - w0, (hi > 100) ? 32'h1 : 32'h0);
		t0 = ticks;
		wait_lvl(0, 1'b0);
		chk("hold ticks", in_rng(ticks - t0, 30, 35), 32'h1);
	endtask : seq
	always @(posedge clk_i)
		if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
			chk("wb read", wb_rd, exp_q.pop_front());
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t0 = ticks;
		@(negedge clk_i);
		chk("boot", {internal_reset, pin_oe, clk_en, gen_clk}, 32'hD);
		rd(rsq_pkg::ADR_CAUSE, 32'h80);
		rd(rsq_pkg::ADR_CAUSE, 32'h0);
		seed = lfsr(seed);
		wb(1'b1, 8'hF0, seed);
		rd(8'hF0, 32'h0);
		seq(4126, 4134);
		chk("clk en", clk_en, 32'h1);
		chk("stack", stk, rsq_pkg::STACK_SET);
		wb(1'b1, rsq_pkg::ADR_WDOG, seed);
		wb(1'b1, rsq_pkg::ADR_IRQ_EN, 32'h28);
		@(posedge clk_i);
		irq <= 24'h00002A;
		cpu_op(F_DONE | F_MASK, 8'h00);
		@(negedge clk_i);
		chk("masked", pend, 32'h0);
		cpu_op(F_DONE, 8'h00);
		@(negedge clk_i);
		chk("latch", {pend, code}, 32'h23);
		rd(rsq_pkg::ADR_STATUS, 32'hA3);
		wb(1'b1, rsq_pkg::ADR_IRQ_EN, 32'h2A);
		cpu_op(F_DONE, 8'h00);
		@(negedge clk_i);
		chk("no preempt", code, 32'h3);
		cpu_op(F_SERV, 8'h00);
		cpu_op(F_DONE, 8'h00);
		@(negedge clk_i);
		chk("next", {pend, code}, 32'h21);
		cpu_op(F_MASK, 8'h00);
		cpu_op(6'h00, 8'h00);
		@(negedge clk_i);
		chk("mask clear", pend, 32'h0);
		@(posedge clk_i);
		irq <= 24'h0;
		seed = lfsr(seed);
		cpu_op(F_UNM, seed[7:0]);
		repeat (4) @(negedge clk_i);
		chk("data fetch", internal_reset, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, rsq_pkg::ADR_CONFIG, (i == 3) ? 32'h2 : 32'h0);
			if (i == 3) cpu_op(F_OP, rsq_pkg::OP_SP_PREFIX);
			t0 = ticks;
			cpu_op(fl[i], (i > 1) ? rsq_pkg::OP_STOP : 8'h00);
			@(negedge clk_i);
			chk("event", {internal_reset, pin_oe}, 32'h3);
			seq(31, 35);
			rd(rsq_pkg::ADR_CAUSE, cs[i]);
		end
		wb(1'b1, rsq_pkg::ADR_CONFIG, 32'h6);
		cpu_op(F_OP, rsq_pkg::OP_STOP);
		repeat (4) @(negedge clk_i);
		chk("stop", {internal_reset, gen_clk, clk_en}, 32'h0);
		@(posedge clk_i);
		brk <= 1'b1;
		t0 = ticks;
		wait_lvl(2, 1'b1);
		chk("wake ticks", in_rng(ticks - t0, 30, 38), 32'h1);
		@(posedge clk_i);
		brk <= 1'b0;
		wb(1'b1, rsq_pkg::ADR_CONFIG, 32'h0);
		@(posedge clk_i);
		lv <= 1'b1;
		repeat (8) @(negedge clk_i);
		chk("lv", {internal_reset, pin_oe}, 32'h3);
		repeat (200) @(posedge clk_i);
		lv <= 1'b0;
		t0 = ticks;
		seq(4126, 4134);
		rd(rsq_pkg::ADR_CAUSE, 32'h02);
		@(posedge clk_i);
		ext_low <= 1'b1;
		repeat (100) @(posedge clk_i);
		ext_low <= 1'b0;
		@(negedge clk_i);
		chk("pin reset", {internal_reset, pin_oe}, 32'h2);
		wait_lvl(0, 1'b0);
		rd(rsq_pkg::ADR_CAUSE, 32'h40);
		t0 = ticks;
		wait_lvl(1, 1'b1);
		chk("wd ticks", in_rng(ticks - t0, 4090, 8200), 32'h1);
		t0 = ticks;
		@(negedge clk_i);
		seq(31, 35);
		rd(rsq_pkg::ADR_CAUSE, 32'h20);
		@(posedge clk_i);
		por <= 1'b1;
		t0 = ticks;
		repeat (20) @(posedge clk_i);
		por <= 1'b0;
		@(negedge clk_i);
		chk("por", {internal_reset, clk_en, gen_clk}, 32'h5);
		seq(4124, 4140);
		rd(rsq_pkg::ADR_CAUSE, 32'h80);
		report_and_stop();
	end
endmodule : rsq_reset_seq_tb
